// >>> common/rrs_map.svh
`ifndef RRS_MAP_SVH
`define RRS_MAP_SVH

// Reset values of the working register and the status flags
`define RRS_WORK_RST  8'h00
`define RRS_FLAGS_RST 6'h00

// Width of the data path and the nibble boundary for the half borrow
`define RRS_DW        8
`define RRS_NIB_W     4

// Cycles from a taken operation to its results at the outputs
`define RRS_LATENCY   1

`endif

// >>> common/rrs_pkg.sv
`include "rrs_map.svh"

package rrs_pkg;

	// Operations carried out by the slice
	typedef enum logic [2:0]
	{
		RRS_ROTATE_RIGHT_MEM,
		RRS_ROTATE_RIGHT_TO_WORKING,
		RRS_ROTATE_RIGHT_THRU_CARRY_MEM,
		RRS_ROTATE_RIGHT_THRU_CARRY_TO_WORKING,
		RRS_SUBTRACT_BORROW_TO_WORKING,
		RRS_SUBTRACT_BORROW_TO_MEM
	} rrs_op_e;

	// Status flags, packed in this order
	typedef struct packed
	{
		logic sign_wrap_flag;
		logic signed_result_flag;
		logic chained_zero_flag;
		logic nibble_borrow_flag;
		logic zero_flag;
		logic carry_flag;
	} rrs_flags_s;

	// Memory write request towards the data memory
	typedef struct packed
	{
		logic                    wr;
		logic [`RRS_DW-1:0]      data;
	} rrs_mem_wr_s;

	// Result of one subtract with borrow
	typedef struct packed
	{
		logic [`RRS_DW-1:0]      diff;
		rrs_flags_s              flags;
	} rrs_sub_s;

endpackage

// >>> logic/rrs_alu.sv
`timescale 1ns/1ps
`include "rrs_map.svh"

// Behaviour
// - Memory rotate right, bit 0 up, flags kept
// - Rotate right into working register, memory kept
// - Memory rotate through carry, nine-bit ring
// - Rotate through carry into working, carry updated
// - Working minus memory minus inverted carry, to working
// - Same difference written back to memory
// - Carry cleared if negative, else set
// - Subtracts update all six flags, carry rotations only the carry
module rrs_alu
(
	input  wire logic                 core_clk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 ce_i,
	input  wire logic                 op_valid_i,
	input  wire rrs_pkg::rrs_op_e     op_i,
	input  wire logic [`RRS_DW-1:0]   mem_rdata_i,
	input  wire logic                 work_load_i,
	input  wire logic [`RRS_DW-1:0]   work_data_i,
	input  wire logic                 flags_load_i,
	input  wire rrs_pkg::rrs_flags_s  flags_data_i,
	output rrs_pkg::rrs_mem_wr_s      mem_wr_o,
	output logic [`RRS_DW-1:0]        working_o,
	output rrs_pkg::rrs_flags_s       flags_o,
	output logic                      done_o
);

	// Right rotation with a chosen bit entering the top
	function automatic logic [`RRS_DW-1:0] rot_right(input logic [`RRS_DW-1:0] v,
		input logic top);
		rot_right = {top, v[`RRS_DW-1:1]};
	endfunction

	// Subtract with borrow; carry in is the inverted borrow
	function automatic rrs_pkg::rrs_sub_s sub_borrow(input logic [`RRS_DW-1:0] a,
		input logic [`RRS_DW-1:0] b, input rrs_pkg::rrs_flags_s f);
		logic [`RRS_DW:0]       full;
		logic [`RRS_NIB_W:0]    low;
		rrs_pkg::rrs_sub_s      r;
		full = {1'b0, a} - {1'b0, b} - {{`RRS_DW{1'b0}}, ~f.carry_flag};
		low  = {1'b0, a[`RRS_NIB_W-1:0]} - {1'b0, b[`RRS_NIB_W-1:0]}
			- {{`RRS_NIB_W{1'b0}}, ~f.carry_flag};
		r.diff                     = full[`RRS_DW-1:0];
		r.flags.carry_flag         = ~full[`RRS_DW];
		r.flags.zero_flag          = (full[`RRS_DW-1:0] == 8'h00);
		r.flags.nibble_borrow_flag = low[`RRS_NIB_W];
		r.flags.sign_wrap_flag     = (a[`RRS_DW-1] != b[`RRS_DW-1])
			&& (full[`RRS_DW-1] != a[`RRS_DW-1]);
		r.flags.signed_result_flag = r.flags.sign_wrap_flag ^ full[`RRS_DW-1];
		r.flags.chained_zero_flag  = r.flags.zero_flag & f.zero_flag;
		sub_borrow = r;
	endfunction

	logic                  take;
	logic [`RRS_DW-1:0]    rot_plain;
	logic [`RRS_DW-1:0]    rot_carry;
	rrs_pkg::rrs_sub_s     sub_res;

	// Operation is taken only with the clock enable high
	assign take      = ce_i && op_valid_i;
	assign rot_plain = rot_right(mem_rdata_i, mem_rdata_i[0]);
	assign rot_carry = rot_right(mem_rdata_i, flags_o.carry_flag);
	assign sub_res   = sub_borrow(working_o, mem_rdata_i, flags_o);

	// Memory write port; write strobe per memory result, held until the next clock-enabled edge
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mem_wr_o <= '0;
		end
		else if (ce_i)
		begin
			mem_wr_o.wr <= 1'b0;
			if (take)
			begin
				case (op_i)
					rrs_pkg::RRS_ROTATE_RIGHT_MEM:
					begin
						mem_wr_o.wr   <= 1'b1;
						mem_wr_o.data <= rot_plain;
					end
					rrs_pkg::RRS_ROTATE_RIGHT_THRU_CARRY_MEM:
					begin
						mem_wr_o.wr   <= 1'b1;
						mem_wr_o.data <= rot_carry;
					end
					rrs_pkg::RRS_SUBTRACT_BORROW_TO_MEM:
					begin
						mem_wr_o.wr   <= 1'b1;
						mem_wr_o.data <= sub_res.diff;
					end
					default:
					begin
						mem_wr_o.wr <= 1'b0; // Working-register ops leave memory alone
					end
				endcase
			end
		end
	end

	// Working register; an operation beats a plain load in the same cycle
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			working_o <= `RRS_WORK_RST;
		end
		else if (ce_i)
		begin
			if (take)
			begin
				case (op_i)
					rrs_pkg::RRS_ROTATE_RIGHT_TO_WORKING:
						working_o <= rot_plain;
					rrs_pkg::RRS_ROTATE_RIGHT_THRU_CARRY_TO_WORKING:
						working_o <= rot_carry;
					rrs_pkg::RRS_SUBTRACT_BORROW_TO_WORKING:
						working_o <= sub_res.diff;
					default:
						working_o <= working_o;
				endcase
			end
			else if (work_load_i)
			begin
				working_o <= work_data_i;
			end
		end
	end

	// Status flags; plain rotations touch none of them
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			flags_o <= `RRS_FLAGS_RST;
		end
		else if (ce_i)
		begin
			if (take)
			begin
				case (op_i)
					rrs_pkg::RRS_ROTATE_RIGHT_THRU_CARRY_MEM,
					rrs_pkg::RRS_ROTATE_RIGHT_THRU_CARRY_TO_WORKING:
						flags_o.carry_flag <= mem_rdata_i[0];
					rrs_pkg::RRS_SUBTRACT_BORROW_TO_WORKING,
					rrs_pkg::RRS_SUBTRACT_BORROW_TO_MEM:
						flags_o <= sub_res.flags;
					default:
						flags_o <= flags_o;
				endcase
			end
			else if (flags_load_i)
			begin
				flags_o <= flags_data_i;
			end
		end
	end

	// Completion pulse, one cycle after the operation is taken
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			done_o <= 1'b0;
		end
		else if (ce_i)
		begin
			done_o <= op_valid_i;
		end
	end

	// Checks next to the logic they guard
	plain_rot_mem_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && op_i == rrs_pkg::RRS_ROTATE_RIGHT_MEM |=> mem_wr_o.wr
		&& mem_wr_o.data == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])}
		&& flags_o == $past(flags_o))
		else $error("plain memory rotate wrong");

	plain_rot_work_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && op_i == rrs_pkg::RRS_ROTATE_RIGHT_TO_WORKING |=> !mem_wr_o.wr
		&& working_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])}
		&& $stable(flags_o))
		else $error("plain rotate to working wrong");

	carry_rot_mem_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && op_i == rrs_pkg::RRS_ROTATE_RIGHT_THRU_CARRY_MEM |=> mem_wr_o.wr
		&& mem_wr_o.data == {$past(flags_o.carry_flag), $past(mem_rdata_i[7:1])}
		&& flags_o.carry_flag == $past(mem_rdata_i[0]))
		else $error("carry memory rotate wrong");

	carry_rot_work_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && op_i == rrs_pkg::RRS_ROTATE_RIGHT_THRU_CARRY_TO_WORKING |=> !mem_wr_o.wr
		&& working_o == {$past(flags_o.carry_flag), $past(mem_rdata_i[7:1])}
		&& flags_o.carry_flag == $past(mem_rdata_i[0]))
		else $error("carry rotate to working wrong");

	sub_work_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && op_i == rrs_pkg::RRS_SUBTRACT_BORROW_TO_WORKING |=> !mem_wr_o.wr
		&& working_o == 8'($past(working_o) - $past(mem_rdata_i)
		- 8'(!$past(flags_o.carry_flag))))
		else $error("subtract to working wrong");

	sub_mem_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && op_i == rrs_pkg::RRS_SUBTRACT_BORROW_TO_MEM |=> mem_wr_o.wr
		&& $stable(working_o) && mem_wr_o.data == 8'($past(working_o)
		- $past(mem_rdata_i) - 8'(!$past(flags_o.carry_flag))))
		else $error("subtract to memory wrong");

	sub_carry_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && (op_i == rrs_pkg::RRS_SUBTRACT_BORROW_TO_WORKING
		|| op_i == rrs_pkg::RRS_SUBTRACT_BORROW_TO_MEM) |=> flags_o.carry_flag ==
		({1'b0, $past(working_o)} >= {1'b0, $past(mem_rdata_i)}
		+ 9'(!$past(flags_o.carry_flag))))
		else $error("subtract carry wrong");

	sub_zero_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && op_i == rrs_pkg::RRS_SUBTRACT_BORROW_TO_WORKING
		|=> flags_o.zero_flag == (working_o == 8'h00)
		&& flags_o.signed_result_flag == (flags_o.sign_wrap_flag ^ working_o[7]))
		else $error("subtract flags wrong");

	done_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take ##1 ce_i |-> done_o)
		else $error("done pulse missing");

endmodule

// >>> dv/rrs_mem_model.sv
`timescale 1ns/1ps

// Data memory byte at the current address, with write-through forwarding
module rrs_mem_model
(
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	input  wire rrs_pkg::rrs_mem_wr_s wr_i,
	input  wire logic                 ld_i,
	input  wire logic [7:0]           ld_data_i,
	output logic [7:0]                rdata_o
);
	logic [7:0] byte_reg;

	// A new address wins over a late write aimed at the old one
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			byte_reg <= 8'h00;
		else if (ld_i)
			byte_reg <= ld_data_i;
		else if (wr_i.wr)
			byte_reg <= wr_i.data;
	end

	// Forwarding lets a back-to-back op see the pending write
	assign rdata_o = wr_i.wr ? wr_i.data : byte_reg;
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	logic                 clk;
	logic                 rstn;
	logic                 ce, v, ld, wl, fl, dn, ewr, edone;
	logic [2:0]           opc;
	logic [7:0]           md, ldd, wd, wk, ew, em, ewd;
	rrs_pkg::rrs_flags_s  fd, fo, ef;
	rrs_pkg::rrs_mem_wr_s mw;
	int                   n_mismatch, total_checks;
	int                   seed = 32'h4017f8b3;

	rrs_alu rrs_alu_i (.core_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .op_valid_i(v),
		.op_i(rrs_pkg::rrs_op_e'(opc)), .mem_rdata_i(md), .work_load_i(wl), .work_data_i(wd),
		.flags_load_i(fl), .flags_data_i(fd), .mem_wr_o(mw), .working_o(wk), .flags_o(fo),
		.done_o(dn));
	rrs_mem_model rrs_mem_model_i (.clk_i(clk), .rstn_i(rstn), .wr_i(mw), .ld_i(ld),
		.ld_data_i(ldd), .rdata_o(md));

	// Core clock, 200 MHz
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic wm(logic [2:0] o);
		return o inside {3'h0, 3'h2, 3'h5};
	endfunction

	// Difference and flags of one subtract with borrow
	function automatic rrs_pkg::rrs_sub_s sub(logic [7:0] a, b, rrs_pkg::rrs_flags_s f);
		logic [8:0]        d;
		logic [4:0]        n;
		rrs_pkg::rrs_sub_s s;
		d = {1'b0, a} - {1'b0, b} - {8'h00, !f.carry_flag};
		n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, !f.carry_flag};
		s.diff = d[7:0];
		s.flags.carry_flag = !d[8];
		s.flags.nibble_borrow_flag = n[4];
		s.flags.zero_flag = d[7:0] == 8'h00;
		s.flags.chained_zero_flag = s.flags.zero_flag && f.zero_flag;
		s.flags.sign_wrap_flag = (a[7] != b[7]) && (d[7] != a[7]);
		s.flags.signed_result_flag = s.flags.sign_wrap_flag ^ d[7];
		return s;
	endfunction

	// State expected after the coming edge
	task automatic predict();
		rrs_pkg::rrs_sub_s s;
		logic [7:0]        r, rc;
		if (!ce)
			return;
		s = sub(ew, em, ef);
		r = {em[0], em[7:1]};
		rc = {ef.carry_flag, em[7:1]};
		edone = v;
		ewr = v && wm(opc);
		if (v)
		begin
			case (opc)
				3'h0: ewd = r;
				3'h1: ew = r;
				3'h2: ewd = rc;
				3'h3: ew = rc;
				3'h4: ew = s.diff;
				3'h5: ewd = s.diff;
				default: ;
			endcase
			if (opc inside {3'h2, 3'h3})
				ef.carry_flag = em[0];
			if (opc inside {3'h4, 3'h5})
				ef = s.flags;
		end
		else
		begin
			if (wl)
				ew = wd;
			if (fl)
				ef = fd;
		end
		if (ewr)
			em = ewd;
		else if (ld)
			em = ldd;
	endtask

	task automatic chk_byte(input logic [7:0] g, e, input string m);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic chk_flags(input rrs_pkg::rrs_flags_s g, e);
		chk_byte({2'b00, g}, {2'b00, e}, "flags");
	endtask

	task automatic chk_bit(input logic g, e, input string m);
		chk_byte({7'h00, g}, {7'h00, e}, m);
	endtask

	// Compare settled outputs, then look one edge ahead
	task automatic cyc();
		#1;
		chk_byte(wk, ew, "working");
		chk_flags(fo, ef);
		chk_bit(dn, edone, "done");
		chk_bit(mw.wr, ewr, "write strobe");
		if (ewr)
			chk_byte(mw.data, ewd, "write data");
		chk_byte(md, em, "memory byte");
		predict();
		@(posedge clk);
	endtask

	task automatic drive(input logic c, vv, input logic [2:0] o, input logic l, w, f,
		input logic [7:0] ldv, wdv, input logic [5:0] fdv);
		ce <= c;
		v <= vv;
		opc <= o;
		ld <= l && c && !(vv && wm(o)); // Address changes kept off write edges
		ldd <= ldv;
		wl <= w;
		wd <= wdv;
		fl <= f;
		fd <= fdv;
		cyc();
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		#50000;
		n_mismatch++;
		conclude();
	end

	// Corner cases, then random traffic
	initial
	begin
		{rstn, ce, v, ld, wl, fl, opc, ldd, wd, fd} = '0;
		{ew, em, ewd, ef, ewr, edone} = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		drive(1'b1, 1'b0, 3'h0, 1'b1, 1'b1, 1'b1, 8'h03, 8'h05, 6'h01);
		drive(1'b1, 1'b1, 3'h4, 1'b1, 1'b1, 1'b1, 8'h01, 8'haa, 6'h3e);
		drive(1'b1, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 6'h00);
		drive(1'b1, 1'b1, 3'h2, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 6'h00);
		drive(1'b1, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 6'h00);
		drive(1'b1, 1'b0, 3'h0, 1'b1, 1'b1, 1'b1, 8'hff, 8'h80, 6'h00);
		drive(1'b1, 1'b1, 3'h5, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 6'h00);
		drive(1'b0, 1'b1, 3'h4, 1'b0, 1'b1, 1'b1, 8'h00, 8'h11, 6'h3f);
		drive(1'b1, 1'b1, 3'h6, 1'b0, 1'b1, 1'b1, 8'h00, 8'h22, 6'h3f);
		drive(1'b1, 1'b1, 3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 6'h00);
		$display("test corners done");
		for (int i = 0; i < 3000; i++)
		begin
			logic [31:0] r;
			r = $random(seed);
			drive(r[2:0] != 3'h0, r[4:3] != 2'h0, r[7:5], r[24], r[8], r[9], r[31:25] * 8'h25,
				r[17:10], r[23:18]);
		end
		$display("test random done");
		conclude();
	end
endmodule
